/* rtl/ccg_clock_control.sv */
`timescale 1ns/100ps
// Contract
// (R1) decode four-bit source field into five families
// (R2) fuse one is unprogrammed, zero programmed
// (R3) deep-sleep wake waits start-up on source
// (R4) reset adds extra delay on watchdog oscillator
// (R5) extra delay is 4096 or 65536 cycles; the code adds none for crystal settings 010 and 101
// (R6) delivery default: source 0001, start-up 10
// (R7) core clock gating stops core operation
// (R8) program memory clock follows core clock
// (R9) peripheral clock drives timers, serial, interrupts
// (R10) async external interrupts wake with gated peripherals
// (R11) two-wire address match works in all sleeps
// (R12) async timer clock runs during sleep
// (R13) async timer only with internal oscillator
// (R14) converter clock separate, others gated in conversion; the code keeps the async timer clock on there
// (R15) each sleep mode gates unused domains
// (R16) selected source feeds central generator domains
// (R17) crystal lsb plus start-up fuses pick count
// (R18) fuses sampled at reset, static while running
module ccg_clock_control
    import ccg_pkg::*;
#(
    parameter logic [CNT_W-1:0] XTAL_LONG_CK = 17'h04000,
    parameter logic [CNT_W-1:0] LF_LONG_CK   = 17'h08000,
    parameter logic [CNT_W-1:0] WDT_LONG_CYC = 17'h10000
)
(
    input  wire logic   clk_sys,         // system clock, 20 MHz
    input  wire logic   rst_n,           // async reset, active low
    input  ccg_fuse_t   fuse_pins,       // fuse bits, read once after reset
    input  wire logic   src_tick,        // one pulse per selected-source cycle
    input  wire logic   wdt_tick,        // one pulse per watchdog osc cycle
    input  wire logic   sleep_req,       // core asks to enter sleep
    input  wire logic [2:0] sleep_mode,  // requested sleep mode
    input  wire logic   async_timer_on,  // software wants the async timer
    input  ccg_wake_t   wake_src,        // wake-up event levels
    output ccg_clk_en_t clk_en,          // per-domain clock enables
    output logic        core_running,    // core may execute instructions
    output logic        startup_busy,    // a start-up delay is being counted
    output ccg_src_t    src_kind,        // decoded clock source family
    output logic        async_timer_ok   // async timer usable with this source
);

    typedef enum logic [5:0] {
        ST_CAPTURE   = 6'h01,
        ST_OSC_START = 6'h02,
        ST_RST_DELAY = 6'h04,
        ST_RUN       = 6'h08,
        ST_SLEEP     = 6'h10,
        ST_WAKE      = 6'h20
    } ccg_state_t;

    ccg_state_t       state_reg;
    ccg_state_t       state_next;
    ccg_fuse_t        fuse_reg;
    ccg_fuse_t        fuse_next;
    ccg_fuse_t        fuse_eff;
    logic [2:0]       mode_reg;
    logic [2:0]       mode_next;
    ccg_clk_en_t      clk_en_reg;
    ccg_clk_en_t      clk_en_next;
    logic             running_reg;
    logic             running_next;
    logic             busy_reg;
    logic             busy_next;
    ccg_src_t         src_reg;
    logic             asy_ok_reg;
    logic             asy_ok_next;
    logic             osc_start;
    logic             wdt_start;
    logic             osc_done;
    logic             wdt_done;
    ccg_src_t         src_dec;
    logic [CNT_W-1:0] osc_cycles;
    logic [CNT_W-1:0] wdt_cycles;
    logic             wake_now;
    logic             deep_mode;

    ccg_fuse_decode #(
        .XTAL_LONG_CK (XTAL_LONG_CK),
        .LF_LONG_CK   (LF_LONG_CK),
        .WDT_LONG_CYC (WDT_LONG_CYC)
    ) u_decode (
        .fuses      (fuse_eff),
        .src_kind   (src_dec),
        .osc_cycles (osc_cycles),
        .wdt_cycles (wdt_cycles)
    );

    // start-up after reset and after deep sleep is counted on the source itself
    ccg_tick_counter u_osc_cnt (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .start   (osc_start),
        .tick    (src_tick),                                                // (R3)
        .load    (osc_cycles),
        .busy    (),
        .done    (osc_done)
    );

    // the reset-only extra delay runs off the watchdog oscillator
    ccg_tick_counter u_wdt_cnt (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .start   (wdt_start),
        .tick    (wdt_tick),                                                // (R4)
        .load    (wdt_cycles),
        .busy    (),
        .done    (wdt_done)
    );

    assign deep_mode = (mode_reg == SLEEP_POWER_DOWN) || (mode_reg == SLEEP_POWER_SAVE);

    // fuse_reg still holds the defaults during capture, so decode the pins there
    assign fuse_eff = (state_reg == ST_CAPTURE) ? fuse_pins : fuse_reg;

    // asynchronous sources wake in every mode; clocked ones only if their clock runs
    always_comb
    begin
        wake_now = wake_src.async_ext_irq                                   // (R10)
                 | wake_src.twi_addr_match                                  // (R11)
                 | (wake_src.sync_irq & clk_en_reg.peripheral_clock)        // (R9)
                 | (wake_src.async_timer_irq & clk_en_reg.async_timer_clock);
    end

    // fsm and start strobes
    always_comb
    begin
        state_next = state_reg;
        fuse_next  = fuse_reg;
        mode_next  = mode_reg;
        osc_start  = 1'b0;
        wdt_start  = 1'b0;
        unique case (state_reg)
            ST_CAPTURE:
            begin
                // one sample after release; later fuse changes are ignored
                fuse_next  = fuse_pins;                                     // (R18)
                state_next = ST_OSC_START;
            end
            ST_OSC_START:
            begin
                if (osc_done)
                begin
                    state_next = ST_RST_DELAY;
                    wdt_start  = 1'b1;                                      // (R4)
                end
            end
            ST_RST_DELAY:
            begin
                if (wdt_done)
                    state_next = ST_RUN;                                    // (R5)
            end
            ST_RUN:
            begin
                if (sleep_req)
                begin
                    mode_next  = sleep_mode;
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                if (wake_now)
                begin
                    if (deep_mode)
                    begin
                        state_next = ST_WAKE;
                        osc_start  = 1'b1;                                  // (R3)
                    end
                    else
                        state_next = ST_RUN;
                end
            end
            ST_WAKE:
            begin
                if (osc_done)
                    state_next = ST_RUN;                                    // (R3)
            end
        endcase
        // the decode sees the pins during capture, so the loaded count matches them
        if (state_reg == ST_CAPTURE)
            osc_start = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_CAPTURE;
            fuse_reg  <= '{clock_source_select_fuses: CKSEL_DEFAULT,        // (R6)
                           startup_time_fuses:        SUT_DEFAULT};
            mode_reg  <= SLEEP_IDLE;
        end
        else
        begin
            state_reg <= state_next;
            fuse_reg  <= fuse_next;
            mode_reg  <= mode_next;
        end
    end

    // domain enables, decided on the state being entered
    always_comb
    begin
        clk_en_next  = '0;
        running_next = (state_next == ST_RUN);                              // (R7)
        busy_next    = (state_next == ST_OSC_START) || (state_next == ST_RST_DELAY)
                    || (state_next == ST_WAKE);
        asy_ok_next  = (src_dec == SRC_INT_RC);                             // (R13)
        unique case (state_next)
            ST_RUN:
            begin
                // the generator hands the source clock to every domain; the async timer gets it only when switched on with the internal rc
                clk_en_next.core_clock           = 1'b1;                    // (R16)
                clk_en_next.peripheral_clock     = 1'b1;                    // (R9)
                clk_en_next.converter_clock      = 1'b1;                    // (R14)
                clk_en_next.async_timer_clock    = async_timer_on & asy_ok_next;
            end
            ST_SLEEP:
            begin
                unique case (mode_next)                                     // (R15)
                    SLEEP_IDLE:
                    begin
                        clk_en_next.peripheral_clock  = 1'b1;
                        clk_en_next.converter_clock   = 1'b1;
                        clk_en_next.async_timer_clock = async_timer_on & asy_ok_next;
                    end
                    SLEEP_CONV_NR:
                    begin
                        // core and peripherals quiet while the converter samples
                        clk_en_next.converter_clock   = 1'b1;               // (R14)
                        clk_en_next.async_timer_clock = async_timer_on & asy_ok_next;
                    end
                    SLEEP_POWER_SAVE:
                    begin
                        clk_en_next.async_timer_clock = async_timer_on & asy_ok_next; // (R12)
                    end
                    default:
                    begin
                        // power-down, standby and unused codes stop every domain
                        clk_en_next.async_timer_clock = 1'b0;
                    end
                endcase
            end
            ST_CAPTURE, ST_OSC_START, ST_RST_DELAY, ST_WAKE:
            begin
                // the core stays frozen until the delay ends
                clk_en_next.async_timer_clock = async_timer_on & asy_ok_next
                                              & (state_next == ST_WAKE);   // (R12)
            end
        endcase
        clk_en_next.program_memory_clock = clk_en_next.core_clock;          // (R8)
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_en_reg  <= '0;
            running_reg <= 1'b0;
            busy_reg    <= 1'b0;
            src_reg     <= SRC_INT_RC;
            asy_ok_reg  <= 1'b0;
        end
        else
        begin
            clk_en_reg  <= clk_en_next;
            running_reg <= running_next;
            busy_reg    <= busy_next;
            src_reg     <= src_dec;                                         // (R1)
            asy_ok_reg  <= asy_ok_next;
        end
    end

    assign clk_en         = clk_en_reg;
    assign core_running   = running_reg;
    assign startup_busy   = busy_reg;
    assign src_kind       = src_reg;
    assign async_timer_ok = asy_ok_reg;

endmodule

/* rtl/ccg_pkg.sv */
package ccg_pkg;

    // fuse field widths; a fuse bit reads 1 when unprogrammed, 0 when programmed
    localparam int          CKSEL_W            = 4;
    localparam int          SUT_W              = 2;
    localparam int          CNT_W              = 17;
    localparam logic        FUSE_UNPROGRAMMED  = 1'h1;
    localparam logic        FUSE_PROGRAMMED    = 1'h0;

    // clock source code ranges
    localparam logic [3:0]  CKSEL_XTAL_LO      = 4'ha;
    localparam logic [3:0]  CKSEL_LFXTAL       = 4'h9;
    localparam logic [3:0]  CKSEL_RC_LO        = 4'h5;
    localparam logic [3:0]  CKSEL_INTRC_LO     = 4'h1;
    localparam logic [3:0]  CKSEL_EXTCLK       = 4'h0;

    // delivery defaults: internal rc, slowly rising power
    localparam logic [3:0]  CKSEL_DEFAULT      = 4'h1;
    localparam logic [1:0]  SUT_DEFAULT        = 2'h2;

    // start-up counts in cycles of the selected source
    localparam logic [16:0] XTAL_SHORT_CK      = 17'h00102;
    localparam logic [16:0] XTAL_MID_CK        = 17'h00400;
    localparam logic [16:0] OTHER_START_CK     = 17'h00006;

    // extra reset delay in watchdog oscillator cycles
    localparam logic [16:0] WDT_NONE_CYC       = 17'h00000;
    localparam logic [16:0] WDT_SHORT_CYC      = 17'h01000;

    // sleep mode codes
    localparam logic [2:0]  SLEEP_IDLE         = 3'h0;
    localparam logic [2:0]  SLEEP_CONV_NR      = 3'h1;
    localparam logic [2:0]  SLEEP_POWER_DOWN   = 3'h2;
    localparam logic [2:0]  SLEEP_POWER_SAVE   = 3'h3;
    localparam logic [2:0]  SLEEP_STANDBY      = 3'h6;

    typedef enum logic [4:0] {
        SRC_XTAL    = 5'h01,
        SRC_LFXTAL  = 5'h02,
        SRC_EXT_RC  = 5'h04,
        SRC_INT_RC  = 5'h08,
        SRC_EXT_CLK = 5'h10
    } ccg_src_t;

    typedef struct packed {
        logic [CKSEL_W-1:0] clock_source_select_fuses;
        logic [SUT_W-1:0]   startup_time_fuses;
    } ccg_fuse_t;

    typedef struct packed {
        logic core_clock;
        logic program_memory_clock;
        logic peripheral_clock;
        logic async_timer_clock;
        logic converter_clock;
    } ccg_clk_en_t;

    typedef struct packed {
        logic sync_irq;
        logic async_ext_irq;
        logic twi_addr_match;
        logic async_timer_irq;
    } ccg_wake_t;

endpackage

/* rtl/ccg_tick_counter.sv */
`timescale 1ns/100ps
module ccg_tick_counter
    import ccg_pkg::*;
(
    input  wire logic             clk_sys,  // system clock
    input  wire logic             rst_n,    // async reset, active low
    input  wire logic             start,    // load the count
    input  wire logic             tick,     // one pulse per counted cycle
    input  wire logic [CNT_W-1:0] load,     // cycles to count
    output logic                  busy,     // count in progress
    output logic                  done      // one-cycle pulse at the end
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             busy_reg;
    logic             busy_next;
    logic             done_reg;
    logic             done_next;

    always_comb
    begin
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start)
        begin
            cnt_next  = load;
            busy_next = (load != '0);
            done_next = (load == '0);
        end
        else if (busy_reg && tick)
        begin
            cnt_next = cnt_reg - CNT_W'(1);
            if (cnt_reg == CNT_W'(1))
            begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;

endmodule

/* rtl/ccg_fuse_decode.sv */
`timescale 1ns/100ps
module ccg_fuse_decode
    import ccg_pkg::*;
#(
    parameter logic [CNT_W-1:0] XTAL_LONG_CK  = 17'h04000,
    parameter logic [CNT_W-1:0] LF_LONG_CK    = 17'h08000,
    parameter logic [CNT_W-1:0] WDT_LONG_CYC  = 17'h10000
)
(
    input  ccg_fuse_t         fuses,       // captured fuse settings
    output ccg_src_t          src_kind,    // decoded source family
    output logic [CNT_W-1:0]  osc_cycles,  // start-up count on the source
    output logic [CNT_W-1:0]  wdt_cycles   // extra reset delay count
);

    logic [3:0] cksel;
    logic [1:0] sut;
    logic [2:0] xtal_idx;

    assign cksel    = fuses.clock_source_select_fuses;
    assign sut      = fuses.startup_time_fuses;
    assign xtal_idx = {cksel[0], sut};

    always_comb
    begin
        // ranges are compared on the raw bit values: 1 unprogrammed, 0 programmed
        if (cksel >= CKSEL_XTAL_LO)                                         // (R2)
            src_kind = SRC_XTAL;                                            // (R1)
        else if (cksel == CKSEL_LFXTAL)
            src_kind = SRC_LFXTAL;                                          // (R1)
        else if (cksel >= CKSEL_RC_LO)
            src_kind = SRC_EXT_RC;                                          // (R1)
        else if (cksel >= CKSEL_INTRC_LO)
            src_kind = SRC_INT_RC;                                          // (R1)
        else
            src_kind = SRC_EXT_CLK;                                         // (R1)
    end

    always_comb
    begin
        osc_cycles = OTHER_START_CK;
        wdt_cycles = (sut == 2'h0) ? WDT_SHORT_CYC : WDT_LONG_CYC;          // (R5)
        unique case (src_kind)
            SRC_XTAL:
            begin
                // clock-select lsb joins the start-up fuses
                unique case (xtal_idx)                                      // (R17)
                    3'h0: begin osc_cycles = XTAL_SHORT_CK; wdt_cycles = WDT_SHORT_CYC; end
                    3'h1: begin osc_cycles = XTAL_SHORT_CK; wdt_cycles = WDT_LONG_CYC;  end
                    3'h2: begin osc_cycles = XTAL_MID_CK;   wdt_cycles = WDT_NONE_CYC;  end
                    3'h3: begin osc_cycles = XTAL_MID_CK;   wdt_cycles = WDT_SHORT_CYC; end
                    3'h4: begin osc_cycles = XTAL_MID_CK;   wdt_cycles = WDT_LONG_CYC;  end
                    3'h5: begin osc_cycles = XTAL_LONG_CK;  wdt_cycles = WDT_NONE_CYC;  end
                    3'h6: begin osc_cycles = XTAL_LONG_CK;  wdt_cycles = WDT_SHORT_CYC; end
                    3'h7: begin osc_cycles = XTAL_LONG_CK;  wdt_cycles = WDT_LONG_CYC;  end
                endcase
            end
            SRC_LFXTAL:
            begin
                // the reserved start-up code falls back to the slowest setting
                osc_cycles = sut[1] ? LF_LONG_CK : XTAL_MID_CK;
                wdt_cycles = (sut == 2'h0) ? WDT_SHORT_CYC : WDT_LONG_CYC;
            end
            SRC_EXT_RC, SRC_INT_RC, SRC_EXT_CLK:
            begin
                osc_cycles = OTHER_START_CK;
            end
        endcase
    end

endmodule

/* tb/ccg_clock_control_chk.sv */
`timescale 1ns/100ps
module ccg_clock_control_chk
    import ccg_pkg::*;
(
    input wire logic       clk_sys,         // system clock
    input wire logic       rst_n,           // async reset, active low
    input wire logic       sleep_req,       // sleep request
    input wire logic [2:0] sleep_mode,      // requested mode
    input wire logic       async_timer_on,  // async timer wanted
    input ccg_wake_t       wake_src,        // wake events
    input ccg_clk_en_t     clk_en,          // domain enables
    input wire logic       core_running,    // core executing
    input wire logic       startup_busy,    // start-up counting
    input ccg_src_t        src_kind,        // source family
    input wire logic       async_timer_ok   // async timer usable
);
    logic was_run_reg;
    logic asleep;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // the capture cycle looks like sleep at the ports, so sleep only counts after a run
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            was_run_reg <= 1'h0;
        else if (core_running)
            was_run_reg <= 1'h1;
    end
    assign asleep = was_run_reg & ~core_running & ~startup_busy;
    prog_core_a: assert property (clk_en.program_memory_clock == clk_en.core_clock)
        else $error("program memory clock differs from core clock");
    core_en_a: assert property (clk_en.core_clock == core_running)
        else $error("core clock and core running disagree");
    busy_run_a: assert property (startup_busy |-> !core_running && !clk_en.core_clock)
        else $error("core runs during start-up delay");
    asy_gate_a: assert property (clk_en.async_timer_clock |-> async_timer_ok)
        else $error("async timer clock without internal oscillator");
    asy_ok_a: assert property (core_running |-> async_timer_ok == (src_kind == SRC_INT_RC))
        else $error("async timer ok does not follow source");
    src_static_a: assert property (core_running && $past(core_running) |-> $stable(src_kind))
        else $error("source changed while running");
    pd_gate_a: assert property (core_running && sleep_req && sleep_mode == SLEEP_POWER_DOWN
        |=> clk_en == '0 && !core_running) else $error("power-down left a clock on");
    conv_nr_a: assert property (core_running && sleep_req && sleep_mode == SLEEP_CONV_NR
        |=> clk_en.converter_clock && !clk_en.peripheral_clock && !clk_en.core_clock)
        else $error("converter sleep gating wrong");
    idle_a: assert property (core_running && sleep_req && sleep_mode == SLEEP_IDLE
        |=> clk_en.peripheral_clock && clk_en.converter_clock && !core_running)
        else $error("idle gating wrong");
    psave_asy_a: assert property (core_running && sleep_req && sleep_mode == SLEEP_POWER_SAVE
        && async_timer_ok && async_timer_on |=> clk_en.async_timer_clock)
        else $error("async timer stopped in power-save");
    wake_ext_a: assert property (asleep && wake_src.async_ext_irq
        |=> core_running || startup_busy) else $error("async interrupt did not wake");
    wake_twi_a: assert property (asleep && wake_src.twi_addr_match
        |=> core_running || startup_busy) else $error("address match did not wake");
endmodule
bind ccg_clock_control ccg_clock_control_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .sleep_req(sleep_req), .sleep_mode(sleep_mode), .async_timer_on(async_timer_on),
    .wake_src(wake_src), .clk_en(clk_en), .core_running(core_running),
    .startup_busy(startup_busy), .src_kind(src_kind), .async_timer_ok(async_timer_ok));

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench
    import ccg_pkg::*;
;
    localparam int XL = 20;
    localparam int LL = 30;
    localparam int WL = 40;
    logic        clk_sys;
    logic        rst_n;
    ccg_fuse_t   fuse_pins;
    logic        src_tick;
    logic        wdt_tick;
    logic        sleep_req;
    logic [2:0]  sleep_mode;
    logic        async_timer_on;
    ccg_wake_t   wake_src;
    ccg_clk_en_t clk_en;
    logic        core_running;
    logic        startup_busy;
    ccg_src_t    src_kind;
    logic        async_timer_ok;
    int          err_total;
    int          samples_checked;
    logic [5:0]  cases [11] = '{6'h3f, 6'h2a, 6'h35, 6'h30, 6'h26, 6'h25, 6'h14, 6'h23,
                                6'h01, 6'h13, 6'h06};
    logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h2, 3'h7};
    logic [3:0]  wakes [6] = '{4'h8, 4'h1, 4'h2, 4'h4, 4'h4, 4'h2};

    ccg_clock_control #(.XTAL_LONG_CK(17'h00014), .LF_LONG_CK(17'h0001e),
        .WDT_LONG_CYC(17'h00028)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .fuse_pins(fuse_pins), .src_tick(src_tick), .wdt_tick(wdt_tick),
        .sleep_req(sleep_req), .sleep_mode(sleep_mode), .async_timer_on(async_timer_on),
        .wake_src(wake_src), .clk_en(clk_en), .core_running(core_running),
        .startup_busy(startup_busy), .src_kind(src_kind), .async_timer_ok(async_timer_ok));

    initial
    begin
        clk_sys = 1'h0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
            err_total++;
        end
    endtask

    task automatic print_verdict;
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // mode -1 stands for the running state
    function automatic ccg_clk_en_t en_of(input int mode, input logic asy);
        ccg_clk_en_t e;
        e = '0;
        e.async_timer_clock = asy & (mode inside {-1, 0, 1, 3});
        e.converter_clock = mode inside {-1, 0, 1};
        e.peripheral_clock = mode inside {-1, 0};
        e.core_clock = (mode == -1);
        e.program_memory_clock = (mode == -1);
        return e;
    endfunction

    task automatic model(input logic [5:0] f, output int n, output int m, output int k);
        int key;
        key = f[2:0];
        if (f[5:2] >= 4'ha)
        begin
            n = key < 2 ? 258 : key < 5 ? 1024 : XL;
            m = key % 3 == 0 ? 4096 : key % 3 == 1 ? WL : 0;
            k = 1;
        end
        else
        begin
            n = f[5:2] == 4'h9 ? (f[1] ? LL : 1024) : 6;
            m = f[1:0] == 2'h0 ? 4096 : WL;
            k = f[5:2] == 4'h9 ? 2 : f[5:2] >= 4'h5 ? 4 : f[5:2] >= 4'h1 ? 8 : 16;
        end
    endtask

    // random gaps keep the counters honest about counting pulses, not cycles
    task automatic ticks(input int which, input int n);
        int i;
        for (i = 0; i < n; i++)
        begin
            src_tick = (which == 0);
            wdt_tick = (which == 1);
            step;
            src_tick = 1'h0;
            wdt_tick = 1'h0;
            repeat ($urandom_range(2, 0) + 1) step;
        end
        repeat (3) step;
    endtask

    task automatic boot(input logic [5:0] f);
        int n;
        int m;
        int k;
        int i;
        model(f, n, m, k);
        fuse_pins = f;
        async_timer_on = 1'($urandom_range(1, 0));
        rst_n = 1'h0;
        repeat (3) step;
        chk("src_kind_reset", src_kind, 8);
        rst_n = 1'h1;
        for (i = 0; i < 20 && startup_busy !== 1'h1; i++)
            step;
        if (i == 20)
        begin
            err_total++;
            print_verdict;
        end
        step;
        fuse_pins = 6'($urandom);
        chk("src_kind", src_kind, k);
        chk("async_timer_ok", async_timer_ok, k == 8);
        ticks(0, n - 1);
        ticks(1, m);
        chk("core_osc_early", core_running, 0);
        ticks(0, 1);
        if (m > 0)
            ticks(1, m - 1);
        chk("core_wdt_early", core_running, m == 0);
        ticks(1, m > 0);
        chk("core_run", core_running, 1);
        chk("busy_run", startup_busy, 0);
        chk("clk_en_run", clk_en, en_of(-1, async_timer_on && k == 8));
        chk("src_kind_held", src_kind, k);
    endtask

    task automatic nap(input logic [2:0] md, input logic [3:0] w);
        logic slow;
        slow = md inside {SLEEP_POWER_DOWN, SLEEP_POWER_SAVE};
        sleep_mode = md;
        sleep_req = 1'h1;
        step;
        sleep_req = 1'h0;
        step;
        chk("clk_en_sleep", clk_en, en_of(md, 1'h1));
        chk("core_sleep", core_running, 0);
        if (md == SLEEP_POWER_DOWN)
        begin
            wake_src = 4'h8;
            step;
            wake_src = '0;
            step;
            chk("sync_refused", core_running | startup_busy, 0);
        end
        wake_src = w;
        step;
        wake_src = '0;
        step;
        chk("wake_busy", startup_busy, slow);
        if (slow)
        begin
            step;
            ticks(0, 5);
            chk("core_wake_early", core_running, 0);
            ticks(0, 1);
        end
        chk("core_wake", core_running, 1);
        chk("clk_en_wake", clk_en, en_of(-1, 1'h1));
    endtask

    initial
    begin
        rst_n = 1'h0;
        fuse_pins = 6'h06;
        src_tick = 1'h0;
        wdt_tick = 1'h0;
        sleep_req = 1'h0;
        sleep_mode = 3'h0;
        async_timer_on = 1'h0;
        wake_src = '0;
        err_total = 0;
        samples_checked = 0;
        void'($urandom(1));
        foreach (cases[c])
            boot(cases[c]);
        async_timer_on = 1'h1;
        repeat (2) step;
        foreach (modes[j])
            nap(modes[j], wakes[j]);
        print_verdict;
    end
endmodule
